/* File: cgc_clock_gate_osc_pll.v */
// Notes on behaviour
// - set register ones enable peripheral clocks
// - clear register ones disable peripheral clocks
// - state register shows enabled peripheral clocks
// - unimplemented peripheral bits are ignored
// - usb pll lock after start-up time
// - usb pll wait is count times eight
// - bias enable, wait equals count plus one slow cycles
// - oscillator write needs key 0x37
// - crystal stable after programmed start-up time
// - bypass sets crystal stable at once
// - clearing enable and bypass drops stable
// - rc stable after its start-up time
// - crystal wait is field times eight
// - select zero rc, one crystal
// - failure detector works only when enabled
// - count main cycles over sixteen slow periods
// - measure valid only with oscillator on
// - divider zero stops, one bypasses, else divides
// - pll lock after lock count following write
// - multiplier zero stops, else times mul plus one
`include "cgc_defs.vh"

module cgc_clock_gate_osc_pll #(
  parameter SLOW_DIV = `CGC_SLOW_DIV,
  parameter [31:0] IMPL_MASK = `CGC_IMPL_MASK
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire mainClkPin,
  output reg [31:0] periphClkEn,
  output reg usbBiasOn,
  output reg usbPllOn,
  output reg xtalOscOn,
  output reg xtalBypassOn,
  output reg rcOscOn,
  output reg mainSrcXtal,
  output reg clkFailDetOn,
  output reg [7:0] pllDivider,
  output reg [10:0] pllMultiplier,
  output reg [1:0] pllFreqRange,
  output reg pllRunning
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one step of a start-up timer, sticks at zero
  function [10:0] countDown;
    input [10:0] c;
    begin
      countDown = (c == 11'h000) ? 11'h000 : c - 11'h001;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state

  // reset words, sliced per field so no bits are dropped silently
  localparam [31:0] RST_UP = `CGC_RST_USB_PLL;
  localparam [31:0] RST_PL = `CGC_RST_MAIN_PLL;

  reg [31:0] pclkEn_r; // peripheral gate bits
  reg [3:0] biasCnt_r; // bias start-up field
  reg [3:0] upCnt_r; // usb pll start-up field
  reg usb_bias_enable_r;
  reg upEn_r;
  reg xtEn_r;
  reg xtBy_r;
  reg rcEn_r;
  reg [7:0] xtCnt_r; // crystal start-up field
  reg srcSel_r;
  reg clock_fail_detect_enable_r;
  reg [7:0] plDiv_r;
  reg [5:0] plCnt_r;
  reg [1:0] plOut_r;
  reg [10:0] plMul_r;
  reg plBit29_r; // stored as written, read back only

  // start-up timers with busy and done flags
  reg [10:0] biasTmr_r;
  reg biasBusy_r;
  reg biasRdy_r;
  reg [10:0] upTmr_r;
  reg upBusy_r;
  reg upLock_r;
  reg [10:0] xtTmr_r;
  reg xtBusy_r;
  reg xtStable_r;
  reg [10:0] rcTmr_r;
  reg rcBusy_r;
  reg rcStable_r;
  reg [10:0] plTmr_r;
  reg plBusy_r;
  reg plLock_r;

  // slow clock enable
  reg [31:0] slowDiv_r;
  reg slowTick_r;

  // measurement
  reg syncA_r;
  reg syncB_r;
  reg syncC_r;
  reg mainLvl_r; // filtered level of the main clock pin
  reg [4:0] winCnt_r; // slow periods elapsed in window
  reg [15:0] edgeCnt_r;
  reg [15:0] mainFreq_r;
  reg freqValid_r;
  reg cfdFail_r;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire access = psel & penable & pready;
  wire wrEn = access & pwrite;
  wire wrSet = wrEn & (paddr == `CGC_OFS_PCLK_SET);
  wire wrClr = wrEn & (paddr == `CGC_OFS_PCLK_CLR);
  wire wrUp = wrEn & (paddr == `CGC_OFS_USB_PLL);
  // a wrong key discards the whole oscillator write
  wire wrMo = wrEn & (paddr == `CGC_OFS_MAIN_OSC) &
    (pwdata[`CGC_MO_KEY_LO+7:`CGC_MO_KEY_LO] == `CGC_MO_KEY);
  wire wrPl = wrEn & (paddr == `CGC_OFS_MAIN_PLL);
  wire mapped = (paddr == `CGC_OFS_PCLK_SET) | (paddr == `CGC_OFS_PCLK_CLR) |
    (paddr == `CGC_OFS_PCLK_STATE) | (paddr == `CGC_OFS_USB_PLL) |
    (paddr == `CGC_OFS_MAIN_OSC) | (paddr == `CGC_OFS_MEASURE) |
    (paddr == `CGC_OFS_MAIN_PLL) | (paddr == `CGC_OFS_STATUS);

  // new enable values on accepted writes, used for edge detection
  wire newUpEn = pwdata[`CGC_UP_EN];
  wire newBiasEn = pwdata[`CGC_BIAS_EN];
  wire newXtEn = pwdata[`CGC_MO_XT_EN];
  wire newRcEn = pwdata[`CGC_MO_RC_EN];
  wire pllStopped = (plMul_r == 11'h000) | (plDiv_r == 8'h00);

  // read mux, reserved bits read zero
  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h0000_0000;
    case (paddr)
      `CGC_OFS_PCLK_STATE: rdMux = pclkEn_r;
      `CGC_OFS_USB_PLL: begin
        rdMux[`CGC_BIAS_CNT_LO+3:`CGC_BIAS_CNT_LO] = biasCnt_r;
        rdMux[`CGC_BIAS_EN] = usb_bias_enable_r;
        rdMux[`CGC_UP_CNT_LO+3:`CGC_UP_CNT_LO] = upCnt_r;
        rdMux[`CGC_UP_EN] = upEn_r;
      end
      `CGC_OFS_MAIN_OSC: begin
        rdMux[`CGC_MO_CFD_EN] = clock_fail_detect_enable_r;
        rdMux[`CGC_MO_SEL] = srcSel_r;
        rdMux[`CGC_MO_XT_CNT_LO+7:`CGC_MO_XT_CNT_LO] = xtCnt_r;
        rdMux[`CGC_MO_RC_EN] = rcEn_r;
        rdMux[`CGC_MO_XT_BY] = xtBy_r;
        rdMux[`CGC_MO_XT_EN] = xtEn_r;
      end
      `CGC_OFS_MEASURE: begin
        rdMux[`CGC_MF_VALID] = freqValid_r;
        rdMux[15:0] = mainFreq_r;
      end
      `CGC_OFS_MAIN_PLL: begin
        rdMux[`CGC_PL_BIT29] = plBit29_r;
        rdMux[`CGC_PL_MUL_LO+10:`CGC_PL_MUL_LO] = plMul_r;
        rdMux[`CGC_PL_OUT_LO+1:`CGC_PL_OUT_LO] = plOut_r;
        rdMux[`CGC_PL_CNT_LO+5:`CGC_PL_CNT_LO] = plCnt_r;
        rdMux[`CGC_PL_DIV_LO+7:`CGC_PL_DIV_LO] = plDiv_r;
      end
      `CGC_OFS_STATUS: begin
        rdMux[`CGC_ST_XT] = xtStable_r;
        rdMux[`CGC_ST_PLL] = plLock_r;
        rdMux[`CGC_ST_UPLL] = upLock_r;
        rdMux[`CGC_ST_BIAS] = biasRdy_r;
        rdMux[`CGC_ST_RC] = rcStable_r;
        rdMux[`CGC_ST_CFD] = cfdFail_r;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state on every access

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel & penable & ~pready) begin
      // answer one cycle into the access phase
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= pwrite ? 32'h0000_0000 : rdMux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pclkEn_r <= 32'h0000_0000;
      biasCnt_r <= RST_UP[`CGC_BIAS_CNT_LO+3:`CGC_BIAS_CNT_LO];
      upCnt_r <= RST_UP[`CGC_UP_CNT_LO+3:`CGC_UP_CNT_LO];
      usb_bias_enable_r <= 1'b0;
      upEn_r <= 1'b0;
      xtEn_r <= 1'b0;
      xtBy_r <= 1'b0;
      rcEn_r <= 1'b1;
      xtCnt_r <= 8'h00;
      srcSel_r <= 1'b0;
      clock_fail_detect_enable_r <= 1'b0;
      plDiv_r <= 8'h00;
      plCnt_r <= RST_PL[`CGC_PL_CNT_LO+5:`CGC_PL_CNT_LO];
      plOut_r <= 2'h0;
      plMul_r <= 11'h000;
      plBit29_r <= 1'b0;
    end else begin
      // set and clear never touch unimplemented identifiers
      if (wrSet) begin
        pclkEn_r <= pclkEn_r | (pwdata & IMPL_MASK);
      end else if (wrClr) begin
        pclkEn_r <= pclkEn_r & ~(pwdata & IMPL_MASK);
      end
      if (wrUp) begin
        biasCnt_r <= pwdata[`CGC_BIAS_CNT_LO+3:`CGC_BIAS_CNT_LO];
        upCnt_r <= pwdata[`CGC_UP_CNT_LO+3:`CGC_UP_CNT_LO];
        usb_bias_enable_r <= newBiasEn;
        upEn_r <= newUpEn;
      end
      if (wrMo) begin
        xtEn_r <= newXtEn;
        xtBy_r <= pwdata[`CGC_MO_XT_BY];
        rcEn_r <= newRcEn;
        xtCnt_r <= pwdata[`CGC_MO_XT_CNT_LO+7:`CGC_MO_XT_CNT_LO];
        srcSel_r <= pwdata[`CGC_MO_SEL];
        clock_fail_detect_enable_r <= pwdata[`CGC_MO_CFD_EN];
      end
      if (wrPl) begin
        plDiv_r <= pwdata[`CGC_PL_DIV_LO+7:`CGC_PL_DIV_LO];
        plCnt_r <= pwdata[`CGC_PL_CNT_LO+5:`CGC_PL_CNT_LO];
        plOut_r <= pwdata[`CGC_PL_OUT_LO+1:`CGC_PL_OUT_LO];
        plMul_r <= pwdata[`CGC_PL_MUL_LO+10:`CGC_PL_MUL_LO];
        plBit29_r <= pwdata[`CGC_PL_BIT29];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slow clock enable from a divider

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slowDiv_r <= 32'h0000_0000;
      slowTick_r <= 1'b0;
    end else if (slowDiv_r >= SLOW_DIV - 1) begin
      slowDiv_r <= 32'h0000_0000;
      slowTick_r <= 1'b1;
    end else begin
      slowDiv_r <= slowDiv_r + 32'h0000_0001;
      slowTick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // usb bias and usb pll start-up
  // a load of n reports ready after n+1 slow ticks, so zero still waits one

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      biasTmr_r <= 11'h000;
      biasBusy_r <= 1'b0;
      biasRdy_r <= 1'b0;
    end else if (wrUp & newBiasEn & ~usb_bias_enable_r) begin
      biasTmr_r <= {7'h00, pwdata[`CGC_BIAS_CNT_LO+3:`CGC_BIAS_CNT_LO]};
      biasBusy_r <= 1'b1;
      biasRdy_r <= 1'b0;
    end else if (~usb_bias_enable_r) begin
      biasBusy_r <= 1'b0;
      biasRdy_r <= 1'b0;
    end else if (biasBusy_r & slowTick_r) begin
      biasTmr_r <= countDown(biasTmr_r);
      if (biasTmr_r == 11'h000) begin
        biasBusy_r <= 1'b0;
        biasRdy_r <= 1'b1;
      end
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      upTmr_r <= 11'h000;
      upBusy_r <= 1'b0;
      upLock_r <= 1'b0;
    end else if (wrUp & newUpEn & ~upEn_r) begin
      // restart on each off-to-on edge
      upTmr_r <= {4'h0, pwdata[`CGC_UP_CNT_LO+3:`CGC_UP_CNT_LO], 3'h0};
      upBusy_r <= 1'b1;
      upLock_r <= 1'b0;
    end else if (~upEn_r) begin
      upBusy_r <= 1'b0;
      upLock_r <= 1'b0;
    end else if (upBusy_r & slowTick_r) begin
      upTmr_r <= countDown(upTmr_r);
      if (upTmr_r == 11'h000) begin
        upBusy_r <= 1'b0;
        upLock_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crystal and rc oscillator start-up

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xtTmr_r <= 11'h000;
      xtBusy_r <= 1'b0;
      xtStable_r <= 1'b0;
    end else if (wrMo & newXtEn & ~xtEn_r) begin
      xtTmr_r <= {pwdata[`CGC_MO_XT_CNT_LO+7:`CGC_MO_XT_CNT_LO], 3'h0};
      xtBusy_r <= 1'b1;
      xtStable_r <= 1'b0;
    end else if (xtBy_r) begin
      // external clock on the input pin, nothing to wait for
      xtBusy_r <= 1'b0;
      xtStable_r <= 1'b1;
    end else if (~xtEn_r) begin
      xtBusy_r <= 1'b0;
      xtStable_r <= 1'b0;
    end else if (xtBusy_r & slowTick_r) begin
      xtTmr_r <= countDown(xtTmr_r);
      if (xtTmr_r == 11'h000) begin
        xtBusy_r <= 1'b0;
        xtStable_r <= 1'b1;
      end
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // the rc oscillator runs from reset and starts timing at once
      rcTmr_r <= `CGC_RC_STARTUP;
      rcBusy_r <= 1'b1;
      rcStable_r <= 1'b0;
    end else if (wrMo & newRcEn & ~rcEn_r) begin
      rcTmr_r <= `CGC_RC_STARTUP;
      rcBusy_r <= 1'b1;
      rcStable_r <= 1'b0;
    end else if (~rcEn_r) begin
      rcBusy_r <= 1'b0;
      rcStable_r <= 1'b0;
    end else if (rcBusy_r & slowTick_r) begin
      rcTmr_r <= countDown(rcTmr_r);
      if (rcTmr_r == 11'h000) begin
        rcBusy_r <= 1'b0;
        rcStable_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main pll lock, restarted by every write

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      plTmr_r <= 11'h000;
      plBusy_r <= 1'b0;
      plLock_r <= 1'b0;
    end else if (wrPl) begin
      plTmr_r <= {5'h00, pwdata[`CGC_PL_CNT_LO+5:`CGC_PL_CNT_LO]};
      plBusy_r <= 1'b1;
      plLock_r <= 1'b0;
    end else if (pllStopped) begin
      // a stopped pll never reports lock
      plBusy_r <= 1'b0;
      plLock_r <= 1'b0;
    end else if (plBusy_r & slowTick_r) begin
      plTmr_r <= countDown(plTmr_r);
      if (plTmr_r == 11'h000) begin
        plBusy_r <= 1'b0;
        plLock_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main clock measurement and failure detection
  // pin must toggle below a quarter of sys_clk or edges are lost

  wire mainOn = srcSel_r ? (xtEn_r | xtBy_r) : rcEn_r;
  wire mainRise = (syncB_r == syncC_r) & syncC_r & ~mainLvl_r;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
      syncC_r <= 1'b0;
      mainLvl_r <= 1'b0;
    end else begin
      syncA_r <= mainClkPin;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      // level follows only when the last two stages agree
      if (syncB_r == syncC_r) begin
        mainLvl_r <= syncC_r;
      end
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      winCnt_r <= 5'h00;
      edgeCnt_r <= 16'h0000;
      mainFreq_r <= 16'h0000;
      freqValid_r <= 1'b0;
      cfdFail_r <= 1'b0;
    end else if (~mainOn) begin
      winCnt_r <= 5'h00;
      edgeCnt_r <= 16'h0000;
      freqValid_r <= 1'b0;
      cfdFail_r <= 1'b0;
    end else begin
      if (slowTick_r & (winCnt_r == `CGC_MF_WINDOW - 5'h01)) begin
        // window of sixteen slow periods closes
        winCnt_r <= 5'h00;
        edgeCnt_r <= 16'h0000;
        mainFreq_r <= edgeCnt_r;
        freqValid_r <= 1'b1;
        cfdFail_r <= clock_fail_detect_enable_r & (edgeCnt_r == 16'h0000);
      end else begin
        if (slowTick_r) begin
          winCnt_r <= winCnt_r + 5'h01;
        end
        // saturate rather than wrap on a very fast clock
        if (mainRise & (edgeCnt_r != 16'hFFFF)) begin
          edgeCnt_r <= edgeCnt_r + 16'h0001;
        end
        if (~clock_fail_detect_enable_r) begin
          cfdFail_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periphClkEn <= 32'h0000_0000;
      usbBiasOn <= 1'b0;
      usbPllOn <= 1'b0;
      xtalOscOn <= 1'b0;
      xtalBypassOn <= 1'b0;
      rcOscOn <= 1'b0;
      mainSrcXtal <= 1'b0;
      clkFailDetOn <= 1'b0;
      pllDivider <= 8'h00;
      pllMultiplier <= 11'h000;
      pllFreqRange <= 2'h0;
      pllRunning <= 1'b0;
    end else begin
      periphClkEn <= pclkEn_r;
      usbBiasOn <= usb_bias_enable_r;
      usbPllOn <= upEn_r;
      xtalOscOn <= xtEn_r;
      xtalBypassOn <= xtBy_r;
      rcOscOn <= rcEn_r;
      mainSrcXtal <= srcSel_r;
      clkFailDetOn <= clock_fail_detect_enable_r;
      pllDivider <= plDiv_r;
      pllMultiplier <= plMul_r;
      pllFreqRange <= plOut_r;
      pllRunning <= ~pllStopped;
    end
  end

endmodule // cgc_clock_gate_osc_pll

/* File: cgc_defs.vh */
`ifndef CGC_DEFS_VH
`define CGC_DEFS_VH

// register byte offsets
`define CGC_OFS_PCLK_SET 8'h10
`define CGC_OFS_PCLK_CLR 8'h14
`define CGC_OFS_PCLK_STATE 8'h18
`define CGC_OFS_USB_PLL 8'h1C
`define CGC_OFS_MAIN_OSC 8'h20
`define CGC_OFS_MEASURE 8'h24
`define CGC_OFS_MAIN_PLL 8'h28
`define CGC_OFS_STATUS 8'h68

// reset values and implemented peripheral mask
`define CGC_RST_USB_PLL 32'h1020_0000
`define CGC_RST_MAIN_OSC 32'h0000_0008
`define CGC_RST_MAIN_PLL 32'h0000_3F00
`define CGC_IMPL_MASK 32'hFFFF_FFFC

// usb pll config fields
`define CGC_UP_EN 16
`define CGC_UP_CNT_LO 20
`define CGC_BIAS_EN 24
`define CGC_BIAS_CNT_LO 28

// main oscillator fields
`define CGC_MO_XT_EN 0
`define CGC_MO_XT_BY 1
`define CGC_MO_RC_EN 3
`define CGC_MO_XT_CNT_LO 8
`define CGC_MO_KEY_LO 16
`define CGC_MO_SEL 24
`define CGC_MO_CFD_EN 25
`define CGC_MO_KEY 8'h37

// measurement fields
`define CGC_MF_VALID 16
`define CGC_MF_WINDOW 5'h10

// main pll fields
`define CGC_PL_DIV_LO 0
`define CGC_PL_CNT_LO 8
`define CGC_PL_OUT_LO 14
`define CGC_PL_MUL_LO 16
`define CGC_PL_BIT29 29

// status fields
`define CGC_ST_XT 0
`define CGC_ST_PLL 1
`define CGC_ST_UPLL 6
`define CGC_ST_BIAS 7
`define CGC_ST_RC 17
`define CGC_ST_CFD 18

// timing
`define CGC_SYS_HZ 250000000
`define CGC_SLOW_HZ 32768
`define CGC_SLOW_DIV (`CGC_SYS_HZ / `CGC_SLOW_HZ)
`define CGC_UP_SCALE 3
`define CGC_XT_SCALE 3
`define CGC_RC_STARTUP 11'h008

`endif

/* File: cgc_clock_gate_osc_pll_props.sv */
module cgc_clock_gate_osc_pll_props #(
  parameter [31:0] IMPL_MASK = 32'hFFFF_FFFC
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] periphClkEn,
  input wire usbBiasOn,
  input wire usbPllOn,
  input wire xtalOscOn,
  input wire xtalBypassOn,
  input wire rcOscOn,
  input wire mainSrcXtal,
  input wire clkFailDetOn,
  input wire [7:0] pllDivider,
  input wire [10:0] pllMultiplier
);
  ////////////////////////////////////////////////////////////////
  // completed write at the sampling edge
  wire wrDone = psel && penable && pready && pwrite;
  // oscillator enables as seen at the ports
  wire [4:0] oscOut = {rcOscOn, xtalOscOn, xtalBypassOn, mainSrcXtal, clkFailDetOn};
  // same enables as carried by the write word
  wire [4:0] oscWr = {pwdata[3], pwdata[0], pwdata[1], pwdata[24], pwdata[25]};
  wire [1:0] usbWr = {pwdata[16], pwdata[24]};
  wire [18:0] pllWr = {pwdata[26:16], pwdata[7:0]};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // outputs lag the register by one cycle, hence the two-cycle delay
  access_answer_a: assert property ((psel && penable && !pready) |=> pready)
    else $error("no answer after first access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  error_reads_zero_a: assert property ((pready && pslverr) |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  gate_set_a: assert property ((wrDone && paddr == 8'h10) |-> ##2
    ((periphClkEn & $past(pwdata, 2) & IMPL_MASK) == ($past(pwdata, 2) & IMPL_MASK)))
    else $error("set write missed a gate");
  gate_clear_a: assert property ((wrDone && paddr == 8'h14) |-> ##2
    ((periphClkEn & $past(pwdata, 2) & IMPL_MASK) == 32'h0000_0000))
    else $error("clear write missed a gate");
  osc_key_drop_a: assert property ((wrDone && paddr == 8'h20 && pwdata[23:16] != 8'h37)
    |-> ##2 oscOut == $past(oscOut, 2)) else $error("keyless write took effect");
  osc_key_take_a: assert property ((wrDone && paddr == 8'h20 && pwdata[23:16] == 8'h37)
    |-> ##2 oscOut == $past(oscWr, 2)) else $error("oscillator enables wrong");
  usb_enable_a: assert property ((wrDone && paddr == 8'h1C) |-> ##2
    {usbPllOn, usbBiasOn} == $past(usbWr, 2)) else $error("usb enables wrong");
  pll_fields_a: assert property ((wrDone && paddr == 8'h28) |-> ##2
    {pllMultiplier, pllDivider} == $past(pllWr, 2)) else $error("pll fields wrong");
endmodule // cgc_clock_gate_osc_pll_props

bind cgc_clock_gate_osc_pll cgc_clock_gate_osc_pll_props #(.IMPL_MASK(IMPL_MASK)) i_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .periphClkEn(periphClkEn), .usbBiasOn(usbBiasOn), .usbPllOn(usbPllOn),
  .xtalOscOn(xtalOscOn), .xtalBypassOn(xtalBypassOn), .rcOscOn(rcOscOn),
  .mainSrcXtal(mainSrcXtal), .clkFailDetOn(clkFailDetOn), .pllDivider(pllDivider),
  .pllMultiplier(pllMultiplier));

/* File: cgc_clock_gate_osc_pll_tb.sv */
`include "cgc_defs.vh"

module cgc_clock_gate_osc_pll_tb;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  localparam int DIV = 4; // short slow tick keeps start-up waits brief
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic mainClkPin = 1'b0;
  logic pinRun = 1'b1; // main clock pin toggling
  logic [2:0] pinCnt = 3'h0;
  wire [31:0] prdata, periphClkEn;
  wire pready, pslverr, usbBiasOn, usbPllOn, xtalOscOn, xtalBypassOn, rcOscOn;
  wire mainSrcXtal, clkFailDetOn, pllRunning;
  wire [7:0] pllDivider;
  wire [10:0] pllMultiplier;
  wire [1:0] pllFreqRange;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////
  cgc_clock_gate_osc_pll #(.SLOW_DIV(DIV)) i_cgc_clock_gate_osc_pll (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mainClkPin(mainClkPin), .periphClkEn(periphClkEn), .usbBiasOn(usbBiasOn),
    .usbPllOn(usbPllOn), .xtalOscOn(xtalOscOn), .xtalBypassOn(xtalBypassOn),
    .rcOscOn(rcOscOn), .mainSrcXtal(mainSrcXtal), .clkFailDetOn(clkFailDetOn),
    .pllDivider(pllDivider), .pllMultiplier(pllMultiplier), .pllFreqRange(pllFreqRange),
    .pllRunning(pllRunning));
  // 250 MHz system clock
  initial forever #2 sys_clk = ~sys_clk;
  // cycle count; pin period of ten cycles stays well under sys_clk/4
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    pinCnt <= (pinCnt == 3'h4) ? 3'h0 : pinCnt + 3'h1;
    if (pinRun && pinCnt == 3'h4) begin
      mainClkPin <= ~mainClkPin;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkb(input string nm, input logic got, input logic exp);
    chk(nm, {31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  // one transfer; request left up so a following call is back to back
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      tally_and_finish;
    end else begin
      r = prdata;
      e = pslverr;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask
  // bus released while time passes
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  // poll a status bit; cycles until set must fall in the window
  task automatic waitbit(input string nm, input int b, input int lo, input int hi);
    int t0;
    logic [31:0] r;
    t0 = cyc;
    do rd(`CGC_OFS_STATUS, r); while (r[b] !== 1'b1 && cyc - t0 < hi + 8);
    chkb(nm, (cyc - t0 >= lo) && (cyc - t0 <= hi), 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic sc_reset;
    logic [31:0] r;
    logic e;
    chkb("rcOn", rcOscOn, 1'b1);
    rd(`CGC_OFS_PCLK_STATE, r); chk("state", r, 32'h0000_0000);
    rd(`CGC_OFS_USB_PLL, r); chk("usbRst", r, 32'h1020_0000);
    rd(`CGC_OFS_MAIN_OSC, r); chk("oscRst", r, 32'h0000_0008);
    rd(`CGC_OFS_MAIN_PLL, r); chk("pllRst", r, 32'h0000_3F00);
    wr(`CGC_OFS_PCLK_STATE, 32'hFFFF_FFFF); // read-only place
    rd(`CGC_OFS_PCLK_STATE, r); chk("stateRo", r, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0000_0000, r, e);
    chkb("errFlag", e, 1'b1);
    chk("errData", r, 32'h0000_0000);
  endtask
  task automatic sc_gate;
    logic [31:0] r;
    wr(`CGC_OFS_PCLK_SET, 32'hFFFF_FFFF);
    rd(`CGC_OFS_PCLK_STATE, r); chk("setAll", r, 32'hFFFF_FFFC);
    wr(`CGC_OFS_PCLK_CLR, 32'h0000_00F3);
    rd(`CGC_OFS_PCLK_STATE, r); chk("clrSome", r, 32'hFFFF_FF0C);
    wr(`CGC_OFS_PCLK_SET, 32'h0000_0000);
    wr(`CGC_OFS_PCLK_CLR, 32'h0000_0000);
    rd(`CGC_OFS_PCLK_STATE, r); chk("zeroWr", r, 32'hFFFF_FF0C);
    wr(`CGC_OFS_PCLK_CLR, 32'hFFFF_0000);
    wr(`CGC_OFS_PCLK_SET, 32'h0001_0000);
    rd(`CGC_OFS_PCLK_STATE, r); chk("mixed", r, 32'h0001_FF0C);
    idle(3);
    chk("gatePort", periphClkEn, 32'h0001_FF0C);
  endtask
  task automatic sc_usb;
    logic [31:0] r;
    wr(`CGC_OFS_USB_PLL, 32'h3100_0000);
    waitbit("bias", 7, 3 * DIV, 4 * DIV + 8);
    wr(`CGC_OFS_USB_PLL, 32'h3111_0000);
    waitbit("upll", 6, 8 * DIV, 9 * DIV + 8);
    rd(`CGC_OFS_USB_PLL, r); chk("usbCfg", r, 32'h3111_0000);
    wr(`CGC_OFS_USB_PLL, 32'h3100_0000);
    idle(2);
    rd(`CGC_OFS_STATUS, r); chkb("upllOff", r[6], 1'b0);
    wr(`CGC_OFS_USB_PLL, 32'h3111_0000);
    waitbit("upllAgain", 6, 8 * DIV, 9 * DIV + 8);
  endtask
  task automatic sc_osc;
    logic [31:0] r;
    wr(`CGC_OFS_MAIN_OSC, 32'h0036_0001); // wrong key
    rd(`CGC_OFS_MAIN_OSC, r); chk("badKey", r, 32'h0000_0008);
    wr(`CGC_OFS_MAIN_OSC, 32'h0037_0209); // enable with bypass low
    waitbit("xtal", 0, 16 * DIV, 17 * DIV + 8);
    rd(`CGC_OFS_MAIN_OSC, r); chk("oscCfg", r, 32'h0000_0209);
    wr(`CGC_OFS_MAIN_OSC, 32'h0037_0008);
    idle(2);
    rd(`CGC_OFS_STATUS, r); chkb("xtalOff", r[0], 1'b0);
    wr(`CGC_OFS_MAIN_OSC, 32'h0037_000A); // bypass with enable low
    idle(2);
    rd(`CGC_OFS_STATUS, r); chkb("bypass", r[0], 1'b1);
    wr(`CGC_OFS_MAIN_OSC, 32'h0037_0002);
    idle(2);
    rd(`CGC_OFS_STATUS, r); chkb("rcOff", r[17], 1'b0);
    wr(`CGC_OFS_MAIN_OSC, 32'h0037_000A);
    waitbit("rc", 17, 8 * DIV, 9 * DIV + 8);
    wr(`CGC_OFS_MAIN_OSC, 32'h0137_000A);
    idle(3);
    chkb("selXtal", mainSrcXtal, 1'b1);
  endtask
  task automatic sc_meas;
    logic [31:0] r;
    int k;
    wr(`CGC_OFS_MAIN_OSC, 32'h0237_0008); // rc selected, detector on
    k = 0;
    do begin
      rd(`CGC_OFS_MEASURE, r);
      k++;
    end while (r[16] !== 1'b1 && k < 80);
    chkb("valid", r[16], 1'b1);
    // about 6.4 pin periods fit in one 64-cycle window
    chkb("count", r[15:0] >= 16'h0005 && r[15:0] <= 16'h0008, 1'b1);
    rd(`CGC_OFS_STATUS, r); chkb("noFail", r[18], 1'b0);
    pinRun <= 1'b0;
    idle(170);
    rd(`CGC_OFS_STATUS, r); chkb("fail", r[18], 1'b1);
    wr(`CGC_OFS_MAIN_OSC, 32'h0037_0008);
    idle(2);
    rd(`CGC_OFS_STATUS, r); chkb("failOff", r[18], 1'b0);
    pinRun <= 1'b1;
    wr(`CGC_OFS_MAIN_OSC, 32'h0037_0000);
    idle(2);
    rd(`CGC_OFS_MEASURE, r); chkb("srcOff", r[16], 1'b0);
  endtask
  task automatic sc_pll;
    logic [31:0] r;
    logic [31:0] stopWr [2];
    stopWr[0] = 32'h2003_0400; // divider zero
    stopWr[1] = 32'h2000_0402; // multiplier zero
    wr(`CGC_OFS_MAIN_PLL, 32'h2003_4402); // bit 29 set
    waitbit("lock", 1, 4 * DIV, 5 * DIV + 8);
    chk("pllPorts", {10'h000, pllFreqRange, pllRunning, pllMultiplier, pllDivider},
        32'h0018_0302);
    rd(`CGC_OFS_MAIN_PLL, r); chk("pllCfg", r, 32'h2003_4402);
    for (int i = 0; i < 2; i++) begin
      wr(`CGC_OFS_MAIN_PLL, stopWr[i]);
      idle(40);
      rd(`CGC_OFS_STATUS, r); chkb("noLock", r[1], 1'b0);
      chkb("stopped", pllRunning, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    idle(2);
    sc_reset;
    sc_gate;
    sc_usb;
    sc_osc;
    sc_meas;
    sc_pll;
    tally_and_finish;
  end
  // guard against a hang anywhere
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule // cgc_clock_gate_osc_pll_tb
